// [cap_pkg.sv]
// Package: register map, field positions and mode encodings of the counter array
package cap_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;  // counter_control_reg: run + event flags
  localparam logic [7:0] OFF_MODE   = 8'h04;  // counter_mode_reg: source + watchdog
  localparam logic [7:0] OFF_CNTL   = 8'h08;  // counter_low_byte
  localparam logic [7:0] OFF_CNTH   = 8'h0C;  // counter_high_byte
  localparam logic [7:0] OFF_MMODE  = 8'h10;  // module_mode_reg n at +4*n
  localparam logic [7:0] OFF_CMPL   = 8'h30;  // compare_value_low n at +4*n
  localparam logic [7:0] OFF_CMPH   = 8'h50;  // compare_value_high n at +4*n
  localparam logic [7:0] OFF_STAT   = 8'h70;  // pin levels, watchdog reset sticky

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MM_IRQ_EN   = 0;  // module_irq_en
  localparam int MM_PWM_EN   = 1;
  localparam int MM_TOG_EN   = 2;  // toggle_en
  localparam int MM_MAT_EN   = 3;  // match_flag_en
  localparam int MM_CAPF_EN  = 4;  // falling_edge_capture_en
  localparam int MM_CAPR_EN  = 5;  // rising_edge_capture_en
  localparam int MM_CMP_EN   = 6;  // comparator_en
  localparam int CTRL_RUN    = 6;  // counter run bit
  localparam int CM_WDT_EN   = 6;  // watchdog_reset_en, mask 40H
  localparam int CM_SRC_LSB  = 1;  // clock source select [2:1]

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [15:0] CMP_RST    = 16'h0000;
  localparam logic [1:0]  SRC_DIV12  = 2'h0;
  localparam logic [1:0]  SRC_DIV4   = 2'h1;
  localparam logic [1:0]  SRC_T0OVF  = 2'h2;
  localparam logic [1:0]  SRC_EXT    = 2'h3;
  localparam logic [3:0]  DIV12_LAST = 4'hB;
  localparam logic [3:0]  DIV4_LAST  = 4'h3;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          NUM_MOD    = 5;
  localparam int          WDT_MOD    = 4;

endpackage : cap_pkg

// [cap_sync.sv]
// Two-flop synchroniser with edge detection on the second stage
`timescale 1ns/1ns
`default_nettype none
module cap_sync
  import cap_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic din,
  output logic      lvl,
  output logic      rise,
  output logic      fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ----------------------------------------------------------------
  // Sync chain; s2 and s3 feed the edge compare
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Edges come from successive synced samples
  assign lvl  = s2_r;
  assign rise = ce & s2_r & ~s3_r;  // see [R23]
  assign fall = ce & ~s2_r & s3_r;  // see [R23]
endmodule : cap_sync
`default_nettype wire

// [cap_tick.sv]
// Counter advance strobe from the selected clock source
`timescale 1ns/1ns
`default_nettype none
module cap_tick
  import cap_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic [1:0] src,
  input  wire logic       t0_ovf,
  input  wire logic       ext_rise,
  output logic            tick
);
  logic [3:0] div_r;
  logic [3:0] last;

  // ----------------------------------------------------------------
  // Prescaler; one divider serves both divided sources
  // ----------------------------------------------------------------
  assign last = (src == SRC_DIV4) ? DIV4_LAST : DIV12_LAST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 4'h0;
    end else if (ce) begin
      div_r <= (div_r >= last) ? 4'h0 : div_r + 4'h1;
    end
  end

  // Source select, see [R15]
  always_comb begin
    unique case (src)
      SRC_DIV12: tick = ce & (div_r == last);
      SRC_DIV4:  tick = ce & (div_r == last);
      SRC_T0OVF: tick = ce & t0_ovf;
      SRC_EXT:   tick = ce & ext_rise;
    endcase
  end
endmodule : cap_tick
`default_nettype wire

// [cap_top.sv]
// Counter array: capture, compare, toggle, PWM and module 4 watchdog
// Function
// [R1] Valid pin edge in capture mode copies the 16-bit counter into module registers.
// [R2] Capture armed by rising enable, falling enable, or both for either edge.
// [R3] Event flag with its module interrupt enable raises the interrupt request.
// [R4] A later capture overwrites the earlier value with no protection.
// [R5] Hardware only sets event flags; software clears them.
// [R6] Comparator plus match enable sets the flag when counter equals compare.
// [R7] Low compare write disables comparator; high compare write re-enables it. Code skips the disable while PWM is on.
// [R8] Toggle, match and comparator enable invert the pin on each match.
// [R9] Toggle done in hardware; unchanged compare toggles again after rollover.
// [R10] PWM output low while counter low byte below compare low, else high.
// [R11] PWM active when PWM enable and comparator enable both set.
// [R12] PWM reloads low compare from high compare when low byte wraps to zero.
// [R13] One shared 16-bit counter serves all five modules.
// [R14] Software loads high compare with 256 times one minus duty.
// [R15] Counter advances from div 12, div 4, timer 0 overflow or external input.
// [R16] Only module 4 offers watchdog; otherwise usable in any mode.
// [R17] Watchdog match on module 4 issues internal reset, not the external pin.
// [R18] Watchdog reset only while watchdog enable, mask 40H, is set.
// [R19] Software sets module 4 mode 4CH then loads compare low then high.
// [R20] Software refreshes module 4 compare from main program with interrupts off.
// [R21] Mode bit 4 falling capture, bit 5 rising capture, bit 6 comparator.
// [R22] PWM waveform independent of interrupt enable.
// [R23] Capture pins synchronised and edge detected from successive samples.
// [R24] Compare and mode registers clear to zero on reset, no-operation mode.
`timescale 1ns/1ns
`default_nettype none
module cap_top
  import cap_pkg::*;
#(
  parameter int NMOD = NUM_MOD
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            ce,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            t0_ovf,
  input  wire logic            ext_clk_in,
  input  wire logic [NMOD-1:0] module_io_pin_i,
  output logic [NMOD-1:0]      module_io_pin_o,
  output logic [NMOD-1:0]      module_io_pin_oe,
  output logic                 irq_r,
  output logic                 wdt_reset_r
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]     cnt_r;
  logic            run_r;
  logic [1:0]      src_r;
  logic            watchdog_reset_en_r;
  logic [7:0]      mode_r  [NMOD];
  logic [7:0]      cmpl_r  [NMOD];
  logic [7:0]      cmph_r  [NMOD];
  logic [NMOD-1:0] flag_r;
  logic [NMOD-1:0] cmp_dis_r;
  logic [NMOD-1:0] pin_r;
  logic            wdt_seen_r;
  logic            tick;
  logic            ext_rise;
  logic [NMOD-1:0] p_lvl;
  logic [NMOD-1:0] p_rise;
  logic [NMOD-1:0] p_fall;
  logic [NMOD-1:0] ev_cap;
  logic [NMOD-1:0] ev_match;
  logic [NMOD-1:0] hit;
  logic            wrap;

  // ----------------------------------------------------------------
  // Bus write channel state and shared address decode
  // ----------------------------------------------------------------
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_do;
  logic        wr_ok;
  logic [NMOD-1:0] flag_clr;

  // Index decode of per-module windows; returns NMOD when out of range
  function automatic int mod_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    if (a < base || d[1:0] != 2'h0 || d[7:2] >= 6'(NMOD)) return NMOD;
    return int'(d[7:2]);
  endfunction : mod_idx

  // Whole map decode, shared by write response and read path
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == OFF_CTRL) || (a == OFF_MODE) || (a == OFF_CNTL) || (a == OFF_CNTH) ||
           (a == OFF_STAT) || (mod_idx(a, OFF_MMODE) < NMOD) ||
           (mod_idx(a, OFF_CMPL) < NMOD) || (mod_idx(a, OFF_CMPH) < NMOD);
  endfunction : addr_ok

  assign wr_do = ce && aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_ok = addr_ok(aw_addr_r);

  // Address and data accepted in either order, held until the write retires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Global control and counter
  // ----------------------------------------------------------------
  cap_sync u_ext (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .din     (ext_clk_in),
    .lvl     (),
    .rise    (ext_rise),
    .fall    ()
  );

  cap_tick u_tick (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .src      (src_r),
    .t0_ovf   (t0_ovf),
    .ext_rise (ext_rise),
    .tick     (tick)
  );

  assign wrap = tick && run_r && (cnt_r[7:0] == 8'hFF);

  // Low byte of a write lands only when its strobe lane is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r  <= 1'b0;
      src_r  <= SRC_DIV12;
      watchdog_reset_en_r <= 1'b0;
    end else if (wr_do && w_strb_r[0]) begin
      if (aw_addr_r == OFF_CTRL) run_r <= w_data_r[CTRL_RUN];
      if (aw_addr_r == OFF_MODE) begin
        watchdog_reset_en_r <= w_data_r[CM_WDT_EN];  // see [R18]
        src_r  <= w_data_r[CM_SRC_LSB +: 2];  // see [R15]
      end
    end
  end

  // One shared time base for every module
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 16'h0000;
    end else if (wr_do && w_strb_r[0] && aw_addr_r == OFF_CNTL) begin
      cnt_r[7:0] <= w_data_r[7:0];
    end else if (wr_do && w_strb_r[0] && aw_addr_r == OFF_CNTH) begin
      cnt_r[15:8] <= w_data_r[7:0];
    end else if (tick && run_r) begin
      cnt_r <= cnt_r + 16'h0001;  // see [R13] [R15]
    end
  end

  // ----------------------------------------------------------------
  // Per-module logic
  // ----------------------------------------------------------------
  for (genvar n = 0; n < NMOD; n++) begin : g_mod
    logic cmp_on;
    logic pwm_on;
    logic wr_l;
    logic wr_h;

    cap_sync u_pin (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .din     (module_io_pin_i[n]),
      .lvl     (p_lvl[n]),
      .rise    (p_rise[n]),
      .fall    (p_fall[n])
    );

    assign wr_l   = wr_do && w_strb_r[0] && mod_idx(aw_addr_r, OFF_CMPL) == n;
    assign wr_h   = wr_do && w_strb_r[0] && mod_idx(aw_addr_r, OFF_CMPH) == n;
    assign cmp_on = mode_r[n][MM_CMP_EN] && !cmp_dis_r[n];  // see [R21]
    assign pwm_on = mode_r[n][MM_PWM_EN] && mode_r[n][MM_CMP_EN];  // see [R11]
    assign ev_cap[n] = (p_rise[n] && mode_r[n][MM_CAPR_EN]) ||
                       (p_fall[n] && mode_r[n][MM_CAPF_EN]);  // see [R2] [R21]
    // Match counted once, on the tick that steps the counter onto the value
    assign hit[n] = cmp_on && ce && tick && run_r &&
                    ((cnt_r + 16'h0001) == {cmph_r[n], cmpl_r[n]});
    assign ev_match[n] = hit[n] && mode_r[n][MM_MAT_EN];  // see [R6]

    // Mode register; zero at reset is no-operation
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mode_r[n] <= MODE_RST;  // see [R24]
      end else if (wr_do && w_strb_r[0] && mod_idx(aw_addr_r, OFF_MMODE) == n) begin
        mode_r[n] <= {1'b0, w_data_r[6:0]};
      end
    end

    // Compare/capture bytes; capture beats a same-cycle bus write
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmpl_r[n] <= CMP_RST[7:0];  // see [R24]
        cmph_r[n] <= CMP_RST[15:8];
      end else if (ce && ev_cap[n]) begin
        cmpl_r[n] <= cnt_r[7:0];  // see [R1] [R4]
        cmph_r[n] <= cnt_r[15:8];
      end else begin
        if (wr_l) cmpl_r[n] <= w_data_r[7:0];
        else if (ce && pwm_on && wrap) cmpl_r[n] <= cmph_r[n];  // see [R12]
        if (wr_h) cmph_r[n] <= w_data_r[7:0];
      end
    end

    // Low write parks the comparator until the high write, except while PWM is on
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_dis_r[n] <= 1'b0;
      end else if (wr_l && !pwm_on) begin
        cmp_dis_r[n] <= 1'b1;  // see [R7]
      end else if (wr_h) begin
        cmp_dis_r[n] <= 1'b0;  // see [R7]
      end
    end

    // Pin: toggle in hardware, or PWM level; irq enable plays no part
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_r[n] <= 1'b0;
      end else if (ce) begin
        if (pwm_on) begin
          pin_r[n] <= (cnt_r[7:0] >= cmpl_r[n]);  // see [R10] [R22]
        end else if (hit[n] && mode_r[n][MM_TOG_EN] && mode_r[n][MM_MAT_EN]) begin
          pin_r[n] <= ~pin_r[n];  // see [R8] [R9]
        end
      end
    end

    // Output driver enabled only in compare-output modes
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        module_io_pin_oe[n] <= 1'b0;
      end else if (ce) begin
        module_io_pin_oe[n] <= pwm_on || (mode_r[n][MM_CMP_EN] && mode_r[n][MM_TOG_EN]);
      end
    end
  end

  assign module_io_pin_o = pin_r;

  // Flags: hardware sets, software clears by writing zero; set wins
  always_comb begin
    flag_clr = '0;
    if (wr_do && w_strb_r[0] && aw_addr_r == OFF_CTRL) flag_clr = ~w_data_r[NMOD-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= '0;
    end else if (ce) begin
      flag_r <= (flag_r & ~flag_clr) | ev_cap | ev_match;  // see [R5]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and watchdog reset
  // ----------------------------------------------------------------
  logic [NMOD-1:0] ien;
  for (genvar n = 0; n < NMOD; n++) begin : g_ien
    assign ien[n] = mode_r[n][MM_IRQ_EN];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= |(flag_r & ien);  // see [R3]
    end
  end

  // Internal reset pulse from module 4 only, see [R16]; external reset pin never driven
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_reset_r <= 1'b0;
      wdt_seen_r  <= 1'b0;
    end else if (ce) begin
      wdt_reset_r <= watchdog_reset_en_r && hit[WDT_MOD] && mode_r[WDT_MOD][MM_MAT_EN];  // see [R17] [R18]
      if (wdt_reset_r) wdt_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rd;
  always_comb begin
    int i;
    rd = 32'h0000_0000;
    i  = 0;
    if (s_axi_araddr == OFF_CTRL) rd = {24'h0, 1'b0, run_r, 6'(flag_r)};
    else if (s_axi_araddr == OFF_MODE) rd = {24'h0, 1'b0, watchdog_reset_en_r, 3'h0, src_r, 1'b0};
    else if (s_axi_araddr == OFF_CNTL) rd = {24'h0, cnt_r[7:0]};
    else if (s_axi_araddr == OFF_CNTH) rd = {24'h0, cnt_r[15:8]};
    else if (s_axi_araddr == OFF_STAT) rd = {16'h0, 7'h0, wdt_seen_r, 3'h0, 5'(p_lvl)};
    else begin
      i = mod_idx(s_axi_araddr, OFF_MMODE);
      if (i < NMOD) rd = {24'h0, mode_r[i]};
      i = mod_idx(s_axi_araddr, OFF_CMPL);
      if (i < NMOD) rd = {24'h0, cmpl_r[i]};
      i = mod_idx(s_axi_araddr, OFF_CMPH);
      if (i < NMOD) rd = {24'h0, cmph_r[i]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd;
        s_axi_rresp  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  capture_load_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [R1]
    ce && ev_cap[0] |=> {cmph_r[0], cmpl_r[0]} == $past(cnt_r))
    else $error("capture did not load counter");
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [R5]
    ce && (ev_cap[1] || ev_match[1]) |=> flag_r[1])
    else $error("event flag not set");
  irq_req_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [R3]
    ce && flag_r[0] && ien[0] |=> irq_r)
    else $error("irq not raised");
  // Checked on the register, so a dropped park is caught, not only a stray match
  cmp_park_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [R7]
    g_mod[1].wr_l && !g_mod[1].pwm_on |=> cmp_dis_r[1] && !hit[1])
    else $error("low compare write did not park comparator");
  toggle_out_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [R8]
    hit[2] && mode_r[2][MM_TOG_EN] && mode_r[2][MM_MAT_EN] && !mode_r[2][MM_PWM_EN]
    |=> pin_r[2] != $past(pin_r[2]))
    else $error("toggle missed");
  pwm_level_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [R10]
    ce && mode_r[3][MM_PWM_EN] && mode_r[3][MM_CMP_EN] && cnt_r[7:0] < cmpl_r[3]
    |=> !pin_r[3])
    else $error("pwm level wrong");
  pwm_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [R12]
    ce && wrap && mode_r[3][MM_PWM_EN] && mode_r[3][MM_CMP_EN] && !ev_cap[3]
    && mod_idx(aw_addr_r, OFF_CMPL) != 3 |=> cmpl_r[3] == $past(cmph_r[3]))
    else $error("pwm reload missed");
  wdt_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [R17] [R18]
    wdt_reset_r |-> $past(watchdog_reset_en_r) && $past(hit[WDT_MOD]))
    else $error("watchdog reset without cause");

endmodule : cap_top
`default_nettype wire

// [cap_pin_model.sv]
// Partner model: board-side drivers of the module capture pins
`timescale 1ns/1ns
`default_nettype none
module cap_pin_model
(
  input  wire logic       aclk,
  input  wire logic [4:0] lvl,
  output var  logic [4:0] pin = 5'h00
);
  // Pins move on the rising edge itself, with no delay, like a flop driving the board
  always @(posedge aclk) begin
    pin <= lvl;
  end
endmodule : cap_pin_model
`default_nettype wire

// [cap_top_bench.sv]
// Testbench: bus tasks and directed checks for the counter array
`timescale 1ns/1ns
`default_nettype none
module cap_top_bench
  import cap_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, t0 = 1'b0, ext = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, wdt;
  logic [1:0]  bresp, rresp, rsp;
  logic [4:0]  lvl = 5'h00, pin_i, pin_o, pin_oe;
  int          n_fail = 0, compares = 0, cyc = 0, n_wdt = 0;

  // 4 ns clock; the cycle ceiling cuts a hang short
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (wdt === 1'b1) n_wdt++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  cap_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .t0_ovf(t0), .ext_clk_in(ext), .module_io_pin_i(pin_i), .module_io_pin_o(pin_o),
    .module_io_pin_oe(pin_oe), .irq_r(irq), .wdt_reset_r(wdt));
  cap_pin_model pin_u (.aclk(aclk), .lvl(lvl), .pin(pin_i));

  // --------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------
  // Address and data offered together; each dropped at its own handshake edge.
  // bready and rready stay high between calls, so a following call never
  // drives them twice at the edge where the previous one ended.
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
  endtask : wr

  // Read data and response are taken at the edge that shows rvalid
  task rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd = rdata;
    rsp = rresp;
  endtask : rdr

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(OFF_MMODE + 8'h04);
    chk(rd, 32'h0);
    rdr(OFF_CMPL);
    chk(rd, 32'h0);
    rdr(8'hFC);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Counter is stopped, so a capture must see exactly what we loaded
    wr(OFF_MMODE, 8'h21);
    wr(OFF_CNTL, 8'h34);
    wr(OFF_CNTH, 8'h12);
    lvl <= 5'h01;
    repeat (10) @(posedge aclk);
    rdr(OFF_CMPL);
    chk(rd, 32'h34);
    rdr(OFF_CMPH);
    chk(rd, 32'h12);
    rdr(OFF_CTRL);
    chk(rd, 32'h01);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_CNTL, 8'h78);
    lvl <= 5'h00;
    repeat (10) @(posedge aclk);
    rdr(OFF_CMPL);
    chk(rd, 32'h34);
    lvl <= 5'h01;
    repeat (10) @(posedge aclk);
    rdr(OFF_CMPL);
    chk(rd, 32'h78);
    wr(OFF_CTRL, 8'h00);
    rdr(OFF_CTRL);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Compare modes all run from one counter started at zero
    wr(OFF_MMODE, 8'h00);
    wr(OFF_CNTL, 8'h00);
    wr(OFF_CNTH, 8'h00);
    wr(OFF_MMODE + 8'h04, 8'h48);
    wr(OFF_CMPL + 8'h04, 8'h05);
    wr(OFF_CMPH + 8'h04, 8'h00);
    wr(OFF_MMODE + 8'h08, 8'h4C);
    wr(OFF_CMPL + 8'h08, 8'h10);
    wr(OFF_CMPH + 8'h08, 8'h00);
    wr(OFF_MMODE + 8'h0C, 8'h42);
    wr(OFF_CMPH + 8'h0C, 8'hC0);
    wr(OFF_MMODE + 8'h10, 8'h4C);
    wr(OFF_CMPL + 8'h10, 8'h20);
    wr(OFF_CMPH + 8'h10, 8'h01);
    wr(OFF_MODE, 8'h42);
    wr(OFF_CTRL, 8'h40);
    repeat (1300) @(posedge aclk);
    wr(OFF_CTRL, 8'h1F);
    rdr(OFF_CTRL);
    chk(rd, 32'h16);
    chk({31'h0, irq}, 32'h0);
    chk({30'h0, pin_oe[2], pin_o[2]}, 32'h3);
    chk(n_wdt, 32'h1);
    rdr(OFF_CMPL + 8'h0C);
    chk(rd, 32'hC0);
    rdr(OFF_CNTL);
    chk({31'h0, pin_o[3]}, {31'h0, rd[7:0] >= 8'hC0});
    // Counter stepped by timer 0 strobes; watchdog compare parked at 2
    wr(OFF_MODE, 8'h44);
    wr(OFF_CNTL, 8'h00);
    wr(OFF_CNTH, 8'h00);
    wr(OFF_CMPL + 8'h10, 8'h02);
    wr(OFF_CMPH + 8'h10, 8'h00);
    wr(OFF_CTRL, 8'h40);
    t0 <= 1'b1;
    @(posedge aclk);
    t0 <= 1'b0;
    // Compare moved ahead before the counter reaches 2, so no reset may follow
    wr(OFF_CMPL + 8'h10, 8'h08);
    wr(OFF_CMPH + 8'h10, 8'h00);
    repeat (2) begin
      @(posedge aclk);
      t0 <= 1'b1;
      @(posedge aclk);
      t0 <= 1'b0;
    end
    rdr(OFF_CNTL);
    chk(rd, 32'h03);
    chk(n_wdt, 32'h1);
    // External input: pulses held two cycles so the synchroniser sees each one
    wr(OFF_MODE, 8'h46);
    repeat (5) begin
      ext <= 1'b1;
      repeat (2) @(posedge aclk);
      ext <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    rdr(OFF_CNTL);
    chk(rd, 32'h08);
    chk(n_wdt, 32'h2);
    stop_test();
  end
endmodule : cap_top_bench
`default_nettype wire
